// >>> rxcfg_pkg.sv
// shared constants of the single-wire configuration link
package rxcfg_pkg;
  // word layout, first received bit lands in bit 0
  localparam int unsigned    WORD_W        = 15;
  localparam int unsigned    LIM_W         = 6;
  localparam int unsigned    F_OFF         = 0;
  localparam int unsigned    F_SEL         = 1;
  localparam int unsigned    F_LIM         = 3;
  localparam int unsigned    F_LIMIT_EXTENSION_FACTOR        = 9;
  localparam logic [14:0]    MODE_WORD_DEF = 15'h0000;
  localparam logic [14:0]    LIM_WORD_DEF  = 15'h0148;
  localparam logic [5:0]     LIM_MAX_LOW   = 6'h0c;
  localparam logic [5:0]     LIM_MAX_DEF   = 6'h29;
  localparam logic [3:0]     LIMIT_EXTENSION_FACTOR_ON       = 4'h8;
  localparam logic [3:0]     LIMIT_EXTENSION_FACTOR_OFF      = 4'h1;
  // timing, in basic clocks (one basic clock per clk_sys_i cycle)
  localparam int unsigned    CLK_NS        = 10;
  localparam int unsigned    T1_MIN        = 100;
  localparam int unsigned    T1_SHORT_MAX  = 5632;
  localparam int unsigned    T1_LONG_MIN   = 7936;
  localparam int unsigned    T2_DELAY      = 200;
  localparam int unsigned    T3_SYNC       = 100;
  localparam int unsigned    T4_GAP        = 50;
  localparam int unsigned    T5_WIN        = 300;
  localparam int unsigned    T6_FRAME      = 800;
  localparam int unsigned    T7_ZERO       = 150;
  localparam int unsigned    T7_ZERO_MIN   = 20;
  localparam int unsigned    T8_ACK        = 100;
  localparam int unsigned    T9_EQ         = 400;
  localparam int unsigned    T_RST         = 1000;
  localparam int unsigned    MARK_HALF     = 2000;
  localparam int unsigned    DATA_MAX_HALF = 1000;
  localparam int unsigned    HOST_T1_SHORT = 1000;
  localparam int unsigned    HOST_T1_LONG  = 8000;
  localparam int unsigned    CNT_W         = 16;
endpackage : rxcfg_pkg

// >>> rxcfg_if.sv
// shared open-drain data line between receiver and host
`timescale 1ns/100ps
interface rxcfg_if;
  logic dev_out;
  logic dev_oe_n;
  logic host_out;
  logic host_oe_n;
  logic line;

  // pull-up wins unless some party drives its low output
  assign line = !((!dev_oe_n && !dev_out) || (!host_oe_n && !host_out));

  modport dev  (input line, output dev_out, output dev_oe_n);
  modport host (input line, output host_out, output host_oe_n);
endinterface : rxcfg_if

// >>> rxcfg_lowcnt.sv
// low-pulse width meter for the shared line
`timescale 1ns/100ps
module rxcfg_lowcnt #(
  parameter int unsigned W = rxcfg_pkg::CNT_W
) (
  input  wire logic         clk_sys_i,
  input  wire logic         arst_n_i,
  input  wire logic         line_i,
  input  wire logic         hold_i,
  output logic      [W-1:0] cnt_o,
  output logic      [W-1:0] width_o,
  output logic              rel_o
);
  import rxcfg_pkg::*;

  // own drive pauses the count so our own low phases add nothing
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_o <= '0;
    end else if (line_i) begin
      cnt_o <= '0;
    end else if (!hold_i && cnt_o != '1) begin
      cnt_o <= cnt_o + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rel_o   <= 1'b0;
      width_o <= '0;
    end else begin
      rel_o   <= line_i && (cnt_o != '0);
      width_o <= cnt_o;
    end
  end
endmodule : rxcfg_lowcnt

// >>> rxcfg_dev.sv
// receiver end: configuration programming and register conservation
//
// Behaviour
// R1: upper bit-check bound 6 bits, 12..63
// R2: bound defaults 41, sets data clock margins
// R3: supply low or power-up loads defaults
// R4: reset released after minimum period
// R5: reset marker square wave until cleared
// R6: marker slower than any valid data
// R7: host low start pulse, then device masters
// R8: delay, then 15 sync pulses and windows
// R9: low in window writes 0, else 1
// R10: acknowledge pulse when new word equals old
// R11: host writes twice to use acknowledge
// R12: programming accepted asleep or active
// R13: receive path off during transfer
// R14: first bit 1 means off command
// R15: short start ignored while in reset
// R16: long start always works, restores defaults
// R17: host uses long start after marker
// R18: parties only pull low or release
// R19: start width counted in basic clocks
// R20: limit extension factor one or eight
`timescale 1ns/100ps
module rxcfg_dev #(
  parameter int unsigned T1_SHORT_MAX = rxcfg_pkg::T1_SHORT_MAX,
  parameter int unsigned T1_LONG_MIN  = rxcfg_pkg::T1_LONG_MIN,
  parameter int unsigned T_RST        = rxcfg_pkg::T_RST,
  parameter int unsigned MARK_HALF    = rxcfg_pkg::MARK_HALF
) (
  input  wire logic        clk_sys_i,
  input  wire logic        arst_n_i,
  input  wire logic        supply_ok_i,
  rxcfg_if.dev             link,
  output logic      [14:0] mode_word_o,
  output logic      [5:0]  lim_max_o,
  output logic      [8:0]  bit_check_max_o,
  output logic      [6:0]  dclk_margin_o,
  output logic             rx_path_en_o,
  output logic             off_cmd_o,
  output logic             marker_o,
  output logic             in_reset_o
);
  import rxcfg_pkg::*;

  if (T1_LONG_MIN <= T1_SHORT_MAX || T1_SHORT_MAX <= T1_MIN || T1_LONG_MIN >= 16'hffff) begin : g_chk_t1
    $error("start pulse thresholds out of order");
  end
  if (MARK_HALF <= DATA_MAX_HALF || MARK_HALF >= 16'hffff || T_RST >= 16'hffff) begin : g_chk_mark
    $error("marker must be slower than data");
  end

  typedef enum logic [6:0] {
    S_IDLE  = 7'h01,
    S_DELAY = 7'h02,
    S_SYNC  = 7'h04,
    S_GAP   = 7'h08,
    S_WIN   = 7'h10,
    S_REST  = 7'h20,
    S_EQ    = 7'h40
  } rxcfg_dstate_t;

  rxcfg_dstate_t state;
  logic [15:0]   tmr;
  logic [15:0]   por_cnt;
  logic [15:0]   mark_cnt;
  logic          mark_ph;
  logic [3:0]    bitn;
  logic [14:0]   shreg;
  logic          zero_seen;
  logic          ack_pend;
  logic          in_por;
  logic [15:0]   low_cnt;
  logic [15:0]   width;
  logic          rel;
  logic          go_short;
  logic          go_long;
  logic          win_bit;
  logic          last_done;
  logic          next_drive;
  logic [14:0]   lim_word;
  logic [14:0]   old_word;
  logic [3:0]    limit_extension_factor;
  logic [5:0]    new_lim;

  rxcfg_lowcnt #(
    .W (16)
  ) u_lowcnt (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .line_i    (link.line),
    .hold_i    (!link.dev_oe_n),
    .cnt_o     (low_cnt),
    .width_o   (width),
    .rel_o     (rel)
  );

  assign in_por = !supply_ok_i || (por_cnt != T_RST[15:0]); // R3 R4

  // supply back above threshold must last the whole reset period
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      por_cnt <= '0;
    end else if (!supply_ok_i) begin
      por_cnt <= '0; // R3
    end else if (por_cnt != T_RST[15:0]) begin
      por_cnt <= por_cnt + 16'h0001; // R4
    end
  end

  // start width qualification, in basic clocks
  assign go_long  = rel && (width > T1_LONG_MIN[15:0]); // R16 R19
  assign go_short = rel && (width > T1_MIN[15:0]) && (width < T1_SHORT_MAX[15:0]) && !marker_o; // R15
  assign win_bit   = !(zero_seen || low_cnt >= T7_ZERO_MIN[15:0]); // R9
  assign last_done = (state == S_REST) && (tmr == T6_FRAME[15:0] - 16'h0001) && (bitn == 4'he);

  // marker divider runs free; slower than data by construction
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mark_cnt <= '0;
      mark_ph  <= 1'b0;
    end else if (mark_cnt == MARK_HALF[15:0] - 16'h0001) begin
      mark_cnt <= '0;
      mark_ph  <= !mark_ph; // R5 R6
    end else begin
      mark_cnt <= mark_cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      marker_o <= 1'b1;
    end else if (in_por) begin
      marker_o <= 1'b1; // R5
    end else if (state == S_IDLE && go_long) begin
      marker_o <= 1'b0; // R16
    end
  end

  // sleep or active state makes no difference to acceptance
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state     <= S_IDLE;
      tmr       <= '0;
      bitn      <= '0;
      shreg     <= '0;
      zero_seen <= 1'b0;
    end else if (in_por) begin
      state <= S_IDLE;
      tmr   <= '0;
    end else begin
      case (state)
        S_IDLE: begin
          tmr  <= '0;
          bitn <= '0;
          if (go_long || go_short) begin
            state <= S_DELAY; // R7 R12 R15 R16
          end
        end
        S_DELAY: begin
          tmr <= tmr + 16'h0001;
          if (tmr == T2_DELAY[15:0] - 16'h0001) begin
            tmr   <= '0;
            state <= S_SYNC; // R8
          end
        end
        S_SYNC: begin
          tmr <= tmr + 16'h0001;
          if (tmr == T3_SYNC[15:0] - 16'h0001) begin
            state <= S_GAP;
          end
        end
        S_GAP: begin
          tmr       <= tmr + 16'h0001;
          zero_seen <= 1'b0;
          if (tmr == T3_SYNC[15:0] + T4_GAP[15:0] - 16'h0001) begin
            state <= S_WIN; // R8
          end
        end
        S_WIN: begin
          tmr <= tmr + 16'h0001;
          if (low_cnt >= T7_ZERO_MIN[15:0]) begin
            zero_seen <= 1'b1; // R9
          end
          if (tmr == T3_SYNC[15:0] + T4_GAP[15:0] + T5_WIN[15:0] - 16'h0001) begin
            shreg <= {win_bit, shreg[14:1]}; // R9
            state <= S_REST;
          end
        end
        S_REST: begin
          tmr <= tmr + 16'h0001;
          if (tmr == T6_FRAME[15:0] - 16'h0001) begin
            tmr <= '0;
            if (bitn == 4'he) begin
              state <= S_EQ; // R10
            end else begin
              bitn  <= bitn + 4'h1;
              state <= S_SYNC; // R8
            end
          end
        end
        S_EQ: begin
          tmr <= tmr + 16'h0001;
          if (tmr == T9_EQ[15:0] - 16'h0001) begin
            state <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  assign old_word = shreg[F_SEL] ? lim_word : mode_word_o;
  assign new_lim  = shreg[F_LIM +: LIM_W];

  // registers restore on reset and on every long start taken in idle
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_word_o <= MODE_WORD_DEF;
      lim_word    <= LIM_WORD_DEF;
      ack_pend    <= 1'b0;
      off_cmd_o   <= 1'b0;
    end else if (in_por) begin
      mode_word_o <= MODE_WORD_DEF; // R3
      lim_word    <= LIM_WORD_DEF; // R3
      ack_pend    <= 1'b0;
      off_cmd_o   <= 1'b0;
    end else begin
      off_cmd_o <= 1'b0;
      if (state == S_IDLE && go_long) begin
        mode_word_o <= MODE_WORD_DEF; // R16
        lim_word    <= LIM_WORD_DEF; // R16
      end
      if (last_done) begin
        ack_pend <= (shreg == old_word); // R10
        if (shreg[F_OFF]) begin
          off_cmd_o <= 1'b1; // R14
        end else if (!shreg[F_SEL]) begin
          mode_word_o <= shreg;
        end else if (new_lim >= LIM_MAX_LOW) begin
          lim_word <= shreg; // R1
        end
      end
    end
  end

  // open-drain: we only ever pull low or let go
  always_comb begin
    next_drive = 1'b0;
    case (state)
      S_IDLE:  next_drive = marker_o && mark_ph; // R5
      S_SYNC:  next_drive = 1'b1; // R8
      S_EQ:    next_drive = ack_pend && (tmr < T8_ACK[15:0]); // R10
      default: next_drive = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      link.dev_oe_n <= 1'b1;
      link.dev_out  <= 1'b0;
    end else begin
      link.dev_oe_n <= !next_drive; // R18
      link.dev_out  <= 1'b0;
    end
  end

  assign limit_extension_factor = lim_word[F_LIMIT_EXTENSION_FACTOR] ? LIMIT_EXTENSION_FACTOR_ON : LIMIT_EXTENSION_FACTOR_OFF; // R20

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lim_max_o       <= LIM_MAX_DEF;
      bit_check_max_o <= 9'(LIM_MAX_DEF - 6'h01); // R2
      dclk_margin_o   <= 7'(9'(LIM_MAX_DEF - 6'h01) >> 2); // R2
      rx_path_en_o    <= 1'b0;
      in_reset_o      <= 1'b1;
    end else begin
      lim_max_o       <= lim_word[F_LIM +: LIM_W]; // R2
      bit_check_max_o <= 9'((lim_word[F_LIM +: LIM_W] - 6'h01) * limit_extension_factor); // R1 R20
      dclk_margin_o   <= 7'(bit_check_max_o >> 2); // R2
      rx_path_en_o    <= (state == S_IDLE) && !in_por; // R13
      in_reset_o      <= in_por;
    end
  end
endmodule : rxcfg_dev

// >>> rxcfg_host.sv
// host end: issues start pulse, writes bits, watches acknowledge
`timescale 1ns/100ps
module rxcfg_host #(
  parameter int unsigned HOST_T1_SHORT = rxcfg_pkg::HOST_T1_SHORT,
  parameter int unsigned HOST_T1_LONG  = rxcfg_pkg::HOST_T1_LONG
) (
  input  wire logic        clk_sys_i,
  input  wire logic        arst_n_i,
  rxcfg_if.host            link,
  input  wire logic        go_i,
  input  wire logic        long_i,
  input  wire logic [14:0] word_i,
  output logic             busy_o,
  output logic             done_o,
  output logic             ack_o,
  output logic             marker_seen_o
);
  import rxcfg_pkg::*;

  if (HOST_T1_SHORT <= T1_MIN || HOST_T1_SHORT >= T1_SHORT_MAX || HOST_T1_LONG >= 16'hffff) begin : g_chk
    $error("host start pulse lengths unusable");
  end

  typedef enum logic [4:0] {
    H_IDLE  = 5'h01,
    H_START = 5'h02,
    H_WAIT  = 5'h04,
    H_BIT   = 5'h08,
    H_EQ    = 5'h10
  } rxcfg_hstate_t;

  localparam logic [15:0] DRV_ON  = 16'(T3_SYNC + T4_GAP + 1);
  localparam logic [15:0] DRV_OFF = 16'(T3_SYNC + T4_GAP + 1 + T7_ZERO);
  localparam logic [15:0] BIT_END = 16'(T3_SYNC + T4_GAP + T5_WIN);
  localparam logic [15:0] EQ_LEN  = 16'(T6_FRAME - T3_SYNC - T4_GAP - T5_WIN + T9_EQ);

  rxcfg_hstate_t state;
  logic [15:0]   tmr;
  logic [15:0]   t1_len;
  logic [3:0]    bitn;
  logic [14:0]   word;
  logic          sensed_low;

  // only a low we are not causing ourselves counts
  assign sensed_low = !link.line && link.host_oe_n;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state          <= H_IDLE;
      tmr            <= '0;
      t1_len         <= '0;
      bitn           <= '0;
      word           <= '0;
      busy_o         <= 1'b0;
      done_o         <= 1'b0;
      ack_o          <= 1'b0;
      marker_seen_o  <= 1'b0;
      link.host_oe_n <= 1'b1;
      link.host_out  <= 1'b0;
    end else begin
      done_o        <= 1'b0;
      link.host_out <= 1'b0;
      case (state)
        H_IDLE: begin
          tmr  <= '0;
          bitn <= '0;
          if (sensed_low) begin
            marker_seen_o <= 1'b1;
          end
          if (go_i) begin
            word           <= word_i;
            t1_len         <= (long_i || marker_seen_o) ? HOST_T1_LONG[15:0] : HOST_T1_SHORT[15:0]; // R17
            marker_seen_o  <= sensed_low;
            ack_o          <= 1'b0;
            busy_o         <= 1'b1;
            link.host_oe_n <= 1'b0; // R7
            state          <= H_START;
          end
        end
        H_START: begin
          tmr <= tmr + 16'h0001;
          if (tmr == t1_len - 16'h0001) begin
            link.host_oe_n <= 1'b1; // R7 R18
            state          <= H_WAIT;
          end
        end
        H_WAIT: begin
          tmr <= '0;
          if (sensed_low) begin
            state <= H_BIT;
          end
        end
        H_BIT: begin
          tmr <= tmr + 16'h0001;
          if (tmr == DRV_ON && !word[0]) begin
            link.host_oe_n <= 1'b0; // R9
          end
          if (tmr == DRV_OFF) begin
            link.host_oe_n <= 1'b1;
          end
          if (tmr == BIT_END) begin
            tmr  <= '0;
            word <= {1'b1, word[14:1]};
            bitn <= bitn + 4'h1;
            state <= (bitn == 4'he) ? H_EQ : H_WAIT;
          end
        end
        H_EQ: begin
          tmr <= tmr + 16'h0001;
          if (sensed_low) begin
            ack_o <= 1'b1; // R11
          end
          if (tmr == EQ_LEN) begin
            busy_o <= 1'b0;
            done_o <= 1'b1;
            state  <= H_IDLE;
          end
        end
        default: begin
          state <= H_IDLE;
        end
      endcase
    end
  end
endmodule : rxcfg_host

// >>> rxcfg_checker.sv
// concurrent checks of the configuration line and the receiver status
`timescale 1ns/100ps
module rxcfg_checker #(
  parameter int unsigned T_RST     = rxcfg_pkg::T_RST,
  parameter int unsigned MARK_HALF = rxcfg_pkg::MARK_HALF
) (
  input wire logic        clk_sys_i,
  input wire logic        arst_n_i,
  input wire logic        supply_ok_i,
  input wire logic        dev_out,
  input wire logic        dev_oe_n,
  input wire logic        host_out,
  input wire logic [14:0] mode_word_o,
  input wire logic [5:0]  lim_max_o,
  input wire logic [8:0]  bit_check_max_o,
  input wire logic [6:0]  dclk_margin_o,
  input wire logic        rx_path_en_o,
  input wire logic        off_cmd_o,
  input wire logic        marker_o,
  input wire logic        in_reset_o
);
  import rxcfg_pkg::*;

  logic [15:0] lo_cnt;
  logic [15:0] ok_cnt;

  // length of the current device low phase
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) lo_cnt <= 16'h0000;
    else lo_cnt <= dev_oe_n ? 16'h0000 : lo_cnt + 16'h0001;
  end

  // saturating, a long run must not wrap back into the window
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) ok_cnt <= 16'h0000;
    else if (!supply_ok_i) ok_cnt <= 16'h0000;
    else if (ok_cnt != 16'hffff) ok_cnt <= ok_cnt + 16'h0001;
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_low_end;
    $rose(dev_oe_n) && !in_reset_o;
  endsequence
  sequence s_por_end;
    $fell(in_reset_o);
  endsequence

  property p_open_drain;
    dev_out == 1'b0 && host_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("line driven high");

  property p_marker_half;
    s_low_end ##0 (marker_o && $past(marker_o)) |-> lo_cnt == MARK_HALF;
  endproperty
  a_marker_half: assert property (p_marker_half) else $error("marker low phase length");

  // ack pulse has the same length as a sync pulse
  property p_sync_len;
    s_low_end ##0 !marker_o |-> lo_cnt == T3_SYNC;
  endproperty
  a_sync_len: assert property (p_sync_len) else $error("sync pulse length");

  property p_por_enter;
    $fell(supply_ok_i) |-> ##[1:3] in_reset_o;
  endproperty
  a_por_enter: assert property (p_por_enter) else $error("no reset on supply loss");

  property p_por_defaults;
    in_reset_o && $past(in_reset_o) |-> mode_word_o == MODE_WORD_DEF && lim_max_o == LIM_MAX_DEF;
  endproperty
  a_por_defaults: assert property (p_por_defaults) else $error("defaults not loaded");

  property p_por_hold;
    s_por_end |-> ok_cnt >= T_RST && ok_cnt <= T_RST + 3;
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("reset period wrong");

  property p_marker_set;
    s_por_end |-> marker_o;
  endproperty
  a_marker_set: assert property (p_marker_set) else $error("marker missing after reset");

  property p_bound;
    (bit_check_max_o == 9'(lim_max_o) - 9'h001) ||
      (bit_check_max_o == (9'(lim_max_o) - 9'h001) << 3);
  endproperty
  a_bound: assert property (p_bound) else $error("bit check bound wrong");

  property p_margin;
    dclk_margin_o == 7'($past(bit_check_max_o) >> 2);
  endproperty
  a_margin: assert property (p_margin) else $error("data clock margin wrong");

  property p_rx_off;
    in_reset_o || (!dev_oe_n && !marker_o) |-> !rx_path_en_o;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("receive path on in transfer");

  property p_off_pulse;
    off_cmd_o |=> !off_cmd_o;
  endproperty
  a_off_pulse: assert property (p_off_pulse) else $error("off command not a pulse");
endmodule : rxcfg_checker

// >>> tb_rx_config_single_wire_prog.sv
// testbench: host and receiver ends joined on one line, plus a bench-driven line
`timescale 1ns/100ps
module tb_rx_config_single_wire_prog;
  import rxcfg_pkg::*;
  // shortened counts keep the run small; long start still above short max
  localparam int unsigned SMAX  = 300;
  localparam int unsigned LMIN  = 400;
  localparam int unsigned TRST  = 100;
  localparam int unsigned MHALF = 1100;
  // six transfers after the marker checks take about 77500 cycles, ending near cycle 86300
  localparam int unsigned LIMIT = 99800;

  logic        clk_sys_i   = 1'b0;
  logic        arst_n_i    = 1'b0;
  logic        supply_ok_i = 1'b1;
  logic        go_i        = 1'b0;
  logic        long_i      = 1'b0;
  logic [14:0] word_i      = 15'h0000;
  logic [14:0] mode_word_o;
  logic [5:0]  lim_max_o;
  logic [8:0]  bit_check_max_o;
  logic [6:0]  dclk_margin_o;
  logic        rx_path_en_o, off_cmd_o, marker_o, in_reset_o, mk_b;
  logic        busy_o, done_o, ack_o, marker_seen_o;
  logic        off_seen    = 1'b0;
  int          fail_count  = 0;
  int          checks_done = 0;
  int          cyc         = 0;
  time         t0, t1;

  rxcfg_if link_a();
  rxcfg_if link_b();

  rxcfg_dev #(.T1_SHORT_MAX(SMAX), .T1_LONG_MIN(LMIN), .T_RST(TRST), .MARK_HALF(MHALF)) u_rxcfg_dev (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .supply_ok_i(supply_ok_i), .link(link_a),
    .mode_word_o(mode_word_o), .lim_max_o(lim_max_o), .bit_check_max_o(bit_check_max_o),
    .dclk_margin_o(dclk_margin_o), .rx_path_en_o(rx_path_en_o), .off_cmd_o(off_cmd_o),
    .marker_o(marker_o), .in_reset_o(in_reset_o));
  rxcfg_host #(.HOST_T1_SHORT(200), .HOST_T1_LONG(500)) u_rxcfg_host (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .link(link_a), .go_i(go_i), .long_i(long_i),
    .word_i(word_i), .busy_o(busy_o), .done_o(done_o), .ack_o(ack_o), .marker_seen_o(marker_seen_o));
  rxcfg_dev #(.T1_SHORT_MAX(SMAX), .T1_LONG_MIN(LMIN), .T_RST(TRST), .MARK_HALF(MHALF)) u_rxcfg_dev_b (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .supply_ok_i(supply_ok_i), .link(link_b),
    .mode_word_o(), .lim_max_o(), .bit_check_max_o(), .dclk_margin_o(), .rx_path_en_o(),
    .off_cmd_o(), .marker_o(mk_b), .in_reset_o());
  rxcfg_checker #(.T_RST(TRST), .MARK_HALF(MHALF)) u_rxcfg_checker (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .supply_ok_i(supply_ok_i),
    .dev_out(link_a.dev_out), .dev_oe_n(link_a.dev_oe_n), .host_out(link_a.host_out),
    .mode_word_o(mode_word_o), .lim_max_o(lim_max_o), .bit_check_max_o(bit_check_max_o),
    .dclk_margin_o(dclk_margin_o), .rx_path_en_o(rx_path_en_o), .off_cmd_o(off_cmd_o),
    .marker_o(marker_o), .in_reset_o(in_reset_o));

  always #5 clk_sys_i = ~clk_sys_i;

  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  always @(posedge clk_sys_i) begin
    cyc++;
    if (off_cmd_o === 1'b1) off_seen = 1'b1;
    if (cyc == LIMIT) begin
      fail_count++;
      complete_run();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one host transfer; the host must be idle when go is raised
  task automatic xfer(input logic lg, input logic [14:0] w);
    int n;
    @(negedge clk_sys_i);
    go_i = 1'b1;
    long_i = lg;
    word_i = w;
    @(negedge clk_sys_i);
    go_i = 1'b0;
    repeat (3000) @(negedge clk_sys_i);
    check(16'(rx_path_en_o), 16'h0000);
    check(16'(busy_o), 16'h0001);
    n = 0;
    while (done_o !== 1'b1 && n < 20000) begin
      @(negedge clk_sys_i);
      n++;
    end
    check(16'(done_o), 16'h0001);
    repeat (3) @(negedge clk_sys_i);
  endtask : xfer

  // bench-driven low pulse on the second line, inside a marker high phase
  task automatic pulse_b(input int len);
    @(posedge link_b.dev_oe_n);
    @(negedge clk_sys_i);
    link_b.host_oe_n = 1'b0;
    repeat (len) @(negedge clk_sys_i);
    link_b.host_oe_n = 1'b1;
    repeat (300) @(negedge clk_sys_i);
  endtask : pulse_b

  initial begin
    link_b.host_out = 1'b0;
    link_b.host_oe_n = 1'b1;
    repeat (20) @(negedge clk_sys_i);
    check(16'(in_reset_o), 16'h0001);
    check(16'(marker_o), 16'h0001);
    check(16'(rx_path_en_o), 16'h0000);
    check(16'(mode_word_o), 16'(MODE_WORD_DEF));
    check(16'(lim_max_o), 16'(LIM_MAX_DEF));
    check(16'(bit_check_max_o), 16'(LIM_MAX_DEF - 1));
    arst_n_i = 1'b1;
    repeat (TRST + 5) @(negedge clk_sys_i);
    check(16'(in_reset_o), 16'h0000);
    @(negedge link_a.dev_oe_n);
    t0 = $time;
    @(negedge clk_sys_i);
    check(16'(link_a.line), 16'h0000);
    @(posedge link_a.dev_oe_n);
    t1 = $time;
    @(negedge link_a.dev_oe_n);
    check(16'((t1 - t0) / 10), 16'(MHALF));
    check(16'(($time - t1) / 10), 16'(MHALF));
    check(16'(marker_seen_o), 16'h0001);
    pulse_b(200);
    check(16'(mk_b), 16'h0001);
    pulse_b(500);
    check(16'(mk_b), 16'h0000);
    // long start from marker: limit 12 with extension, then 11 refused at the lower boundary of the field
    @(posedge link_a.dev_oe_n);
    xfer(1'b1, 15'h0262);
    check(16'(marker_o), 16'h0000);
    check(16'(lim_max_o), 16'h000c);
    check(16'(bit_check_max_o), 16'((12 - 1) * 8));
    check(16'(dclk_margin_o), 16'(((12 - 1) * 8) >> 2));
    xfer(1'b0, 15'h005a);
    check(16'(lim_max_o), 16'h000c);
    check(16'(bit_check_max_o), 16'((12 - 1) * 8));
    xfer(1'b0, 15'h5a34);
    check(16'(mode_word_o), 16'h5a34);
    check(16'(ack_o), 16'h0000);
    xfer(1'b0, 15'h5a34);
    check(16'(ack_o), 16'h0001);
    xfer(1'b0, 15'h7fff);
    check(16'(off_seen), 16'h0001);
    check(16'(mode_word_o), 16'h5a34);
    xfer(1'b1, 15'h2ac8);
    check(16'(mode_word_o), 16'h2ac8);
    check(16'(ack_o), 16'h0000);
    check(16'(lim_max_o), 16'(LIM_MAX_DEF));
    check(16'(bit_check_max_o), 16'(LIM_MAX_DEF - 1));
    supply_ok_i = 1'b0;
    repeat (5) @(negedge clk_sys_i);
    check(16'(in_reset_o), 16'h0001);
    check(16'(mode_word_o), 16'(MODE_WORD_DEF));
    supply_ok_i = 1'b1;
    repeat (TRST + 5) @(negedge clk_sys_i);
    check(16'(in_reset_o), 16'h0000);
    check(16'(marker_o), 16'h0001);
    complete_run();
  end
endmodule : tb_rx_config_single_wire_prog
